// >>> hw/ssp_pkg.sv
// ssp_pkg: constants for the serial port pin block
// assumes: 10 MHz system clock, link clock unrelated in phase
package ssp_pkg;
    // ------------------------------------------------------------
    // widths and pin indices
    // ------------------------------------------------------------
    localparam int          NUM_PINS      = 6;
    localparam int          WORD_W        = 16;
    localparam int          CNT_W         = 5;
    localparam int          PIN_CTRL0     = 0;
    localparam int          PIN_CTRL1     = 1;
    localparam int          PIN_CTRL2     = 2;
    localparam int          PIN_BCLK      = 3;
    localparam int          PIN_RXD       = 4;
    localparam int          PIN_TXD       = 5;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0]  RST_PIN_SEL   = 6'h00;
    localparam logic [5:0]  RST_PIN_DIR   = 6'h00;
    localparam logic [CNT_W-1:0] RST_CNT  = 5'h00;
    // ------------------------------------------------------------
    // timing: least bit clock period in system phases
    // ------------------------------------------------------------
    localparam int          MIN_BCLK_PHASES = 6;
    localparam int          SYNC_STAGES   = 3;
    localparam int          BUF_DEPTH     = 2;

    typedef enum logic [1:0] {
        SSP_RUN  = 2'b00,
        SSP_WAIT = 2'b01,
        SSP_STOP = 2'b11
    } ssp_pwr_e;
endpackage : ssp_pkg

// >>> hw/ssp_buf2.sv
// ssp_buf2: two-entry word buffer, valid/ready on both sides
// assumes: single clock domain, read data held in registers
`timescale 1ns/10ps
module ssp_buf2 (
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    // fill side
    input  wire logic                       i_valid,
    output logic                            o_ready,
    input  wire logic [ssp_pkg::WORD_W-1:0] i_data,
    // drain side
    output logic                            o_valid,
    input  wire logic                       i_ready,
    output logic [ssp_pkg::WORD_W-1:0]      o_data
);
    logic [ssp_pkg::WORD_W-1:0] mem_q [ssp_pkg::BUF_DEPTH];
    logic                       wp_q;
    logic                       rp_q;
    logic [1:0]                 cnt_q;
    logic                       push;
    logic                       pop;

    assign o_ready = (cnt_q != 2'h2);
    assign o_valid = (cnt_q != 2'h0);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem_q[rp_q];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wp_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : ssp_buf2

// >>> hw/ssp_port.sv
// ssp_port: pins of the second synchronous serial port with port D
// assumes: pins resolved outside from out/oe; link clock from i_lclk
// How it works
// - async mode, line zero is rx bit clock
// - sync mode, line zero is tx1 or flag0
// - async mode, line one is rx frame sync
// - sync mode, line one is tx2 or flag1
// - line two is frame sync, tx or shared
// - line two output drives internal frame sync
// - line two input gives external frame sync
// - bit clock pin in or out, per mode
// - rx data pin shifted into rx register
// - tx data pin driven while transmitting
// - pins reset as general purpose inputs
// - gpio direction follows direction bits
// - serial function only when control bit set
// - stop state, last input pins ignored
// - stop state, last output level is kept
// - wait state leaves pins unchanged
`timescale 1ns/10ps
module ssp_port (
    // clocks and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_lclk,
    // port control
    input  wire logic [5:0]                 i_pin_sel,
    input  wire logic [5:0]                 i_pin_dir,
    input  wire logic [5:0]                 i_gpio_out,
    output logic [5:0]                      o_gpio_in,
    input  wire logic                       i_async_mode,
    input  wire logic                       i_bclk_out,
    input  wire logic                       i_fs_out,
    input  wire logic                       i_rx_fs_out,
    input  wire logic                       i_flag_mode,
    input  wire logic [1:0]                 i_flag_out,
    input  wire logic                       i_stop,
    input  wire logic                       i_wait,
    // words
    input  wire logic                       i_tx_valid,
    output logic                            o_tx_ready,
    input  wire logic [ssp_pkg::WORD_W-1:0] i_tx_data,
    output logic                            o_rx_valid,
    input  wire logic                       i_rx_ready,
    output logic [ssp_pkg::WORD_W-1:0]      o_rx_data,
    // pins
    input  wire logic [5:0]                 i_pin,
    output logic [5:0]                      o_pin,
    output logic [5:0]                      o_pin_oe
);
    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    ssp_pkg::ssp_pwr_e pwr_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr_q <= ssp_pkg::SSP_RUN;
        end else begin
            unique case (pwr_q)
                ssp_pkg::SSP_RUN: begin
                    if (i_stop) pwr_q <= ssp_pkg::SSP_STOP;
                    else if (i_wait) pwr_q <= ssp_pkg::SSP_WAIT;
                end
                ssp_pkg::SSP_WAIT: begin
                    if (i_stop) pwr_q <= ssp_pkg::SSP_STOP;
                    else if (!i_wait) pwr_q <= ssp_pkg::SSP_RUN;
                end
                ssp_pkg::SSP_STOP: begin
                    if (!i_stop) pwr_q <= ssp_pkg::SSP_RUN;
                end
                default: pwr_q <= ssp_pkg::SSP_RUN;
            endcase
        end
    end
    logic stopped;
    assign stopped = (pwr_q == ssp_pkg::SSP_STOP);

    // ------------------------------------------------------------
    // pin synchronisers, three stages each
    // ------------------------------------------------------------
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [5:0] s3_q;
    logic [5:0] pin_s;
    genvar g;
    generate
        for (g = 0; g < ssp_pkg::NUM_PINS; g++) begin : g_sync
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    pin_s[g] <= 1'b0;
                end else begin
                    s1_q[g] <= i_pin[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) pin_s[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // pin direction and drive
    // ------------------------------------------------------------
    logic [5:0] oe_d;
    logic [5:0] out_d;
    logic [5:0] oe_q;
    logic [5:0] out_q;
    logic       tx_active;
    logic       tx_bit;
    logic       tx1_bit;

    always_comb begin
        oe_d  = i_pin_dir;
        out_d = i_gpio_out;
        if (i_pin_sel[ssp_pkg::PIN_CTRL0]) begin
            if (i_async_mode) begin
                oe_d[0]  = i_bclk_out;
                out_d[0] = pin_s[ssp_pkg::PIN_BCLK];
            end else begin
                oe_d[0]  = 1'b1;
                out_d[0] = i_flag_mode ? i_flag_out[0] : tx1_bit;
            end
        end
        if (i_pin_sel[ssp_pkg::PIN_CTRL1]) begin
            if (i_async_mode) begin
                oe_d[1]  = i_rx_fs_out;
                out_d[1] = i_fs_out;
            end else begin
                oe_d[1]  = 1'b1;
                out_d[1] = i_flag_mode ? i_flag_out[1] : tx_bit;
            end
        end
        if (i_pin_sel[ssp_pkg::PIN_CTRL2]) begin
            oe_d[2]  = i_fs_out;
            out_d[2] = i_fs_out;
        end
        if (i_pin_sel[ssp_pkg::PIN_BCLK]) begin
            oe_d[3]  = i_bclk_out;
            out_d[3] = 1'b0;
        end
        if (i_pin_sel[ssp_pkg::PIN_RXD]) begin
            oe_d[4]  = 1'b0;
            out_d[4] = 1'b0;
        end
        if (i_pin_sel[ssp_pkg::PIN_TXD]) begin
            oe_d[5]  = tx_active;
            out_d[5] = tx_bit;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            oe_q  <= ssp_pkg::RST_PIN_DIR;
            out_q <= 6'h00;
        end else if (pwr_q == ssp_pkg::SSP_RUN) begin
            oe_q  <= oe_d;
            out_q <= out_d;
        end
    end
    // keeper: in stop the pad stays at the last driven value
    assign o_pin    = out_q;
    assign o_pin_oe = oe_q;

    logic [5:0] gin_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gin_q <= 6'h00;
        end else if (!stopped) begin
            gin_q <= pin_s & ~oe_q;
        end
    end
    assign o_gpio_in = gin_q;

    // ------------------------------------------------------------
    // link domain: serial shift on external bit clock
    // ------------------------------------------------------------
    // bit clock slow enough; the toggle crossing needs
    // three phases per half, which the far side guarantees
    logic [ssp_pkg::WORD_W-1:0] lrx_sh_q;
    logic [ssp_pkg::WORD_W-1:0] lrx_word_q;
    logic [ssp_pkg::CNT_W-1:0]  lrx_cnt_q;
    logic                       lrx_tog_q;
    logic [ssp_pkg::WORD_W-1:0] ltx_sh_q;
    logic [ssp_pkg::CNT_W-1:0]  ltx_cnt_q;
    logic                       ltx_tog_q;
    logic                       lfs;
    assign lfs = i_async_mode ? i_pin[ssp_pkg::PIN_CTRL1]
                              : i_pin[ssp_pkg::PIN_CTRL2];

    always_ff @(posedge i_lclk or posedge i_rst) begin
        if (i_rst) begin
            lrx_sh_q   <= '0;
            lrx_word_q <= '0;
            lrx_cnt_q  <= ssp_pkg::RST_CNT;
            lrx_tog_q  <= 1'b0;
        end else begin
            lrx_sh_q <= {lrx_sh_q[ssp_pkg::WORD_W-2:0],
                         i_pin[ssp_pkg::PIN_RXD]};
            if (lfs) begin
                lrx_cnt_q <= 5'h01;
            end else if (lrx_cnt_q != ssp_pkg::RST_CNT) begin
                lrx_cnt_q <= lrx_cnt_q + 5'h01;
            end
            if (lrx_cnt_q == 5'h10) begin
                // the last bit arrives on this edge, so take it here
                lrx_word_q <= {lrx_sh_q[ssp_pkg::WORD_W-2:0],
                               i_pin[ssp_pkg::PIN_RXD]};
                lrx_tog_q  <= ~lrx_tog_q;
                lrx_cnt_q  <= ssp_pkg::RST_CNT;
            end
        end
    end

    // tx word handed to link by toggle handshake
    logic [ssp_pkg::WORD_W-1:0] tx_word_q;
    logic                       tx_req_q;
    logic                       tx_ack_s1_q;
    logic                       tx_ack_s2_q;
    logic                       tx_full_q;
    logic                       tb_valid;
    logic [ssp_pkg::WORD_W-1:0] tb_data;
    logic                       tb_take;
    assign tb_take = tb_valid && !tx_full_q;

    ssp_buf2 u_txbuf (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_valid (i_tx_valid),
        .o_ready (o_tx_ready),
        .i_data  (i_tx_data),
        .o_valid (tb_valid),
        .i_ready (!tx_full_q),
        .o_data  (tb_data)
    );

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_word_q   <= '0;
            tx_req_q    <= 1'b0;
            tx_ack_s1_q <= 1'b0;
            tx_ack_s2_q <= 1'b0;
            tx_full_q   <= 1'b0;
        end else begin
            tx_ack_s1_q <= ltx_tog_q;
            tx_ack_s2_q <= tx_ack_s1_q;
            if (tb_take) begin
                tx_word_q <= tb_data;
                tx_req_q  <= ~tx_req_q;
                tx_full_q <= 1'b1;
            end else if (tx_ack_s2_q == tx_req_q) begin
                tx_full_q <= 1'b0;
            end
        end
    end

    logic lreq_s1_q;
    logic lreq_s2_q;
    always_ff @(posedge i_lclk or posedge i_rst) begin
        if (i_rst) begin
            ltx_sh_q  <= '0;
            ltx_cnt_q <= ssp_pkg::RST_CNT;
            ltx_tog_q <= 1'b0;
            lreq_s1_q <= 1'b0;
            lreq_s2_q <= 1'b0;
        end else begin
            lreq_s1_q <= tx_req_q;
            lreq_s2_q <= lreq_s1_q;
            // transmitter framed by line two in both modes
            if (i_pin[ssp_pkg::PIN_CTRL2] && lreq_s2_q != ltx_tog_q) begin
                ltx_sh_q  <= tx_word_q;
                ltx_cnt_q <= 5'h10;
                ltx_tog_q <= lreq_s2_q;
            end else if (ltx_cnt_q != ssp_pkg::RST_CNT) begin
                ltx_sh_q  <= {ltx_sh_q[ssp_pkg::WORD_W-2:0], 1'b0};
                ltx_cnt_q <= ltx_cnt_q - 5'h01;
            end
        end
    end
    // two-flop crossing of link-side level outputs into i_clk
    logic [1:0] act_s_q;
    logic [1:0] bit_s_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            act_s_q <= 2'b00;
            bit_s_q <= 2'b00;
        end else begin
            act_s_q <= {act_s_q[0], ltx_cnt_q != ssp_pkg::RST_CNT};
            bit_s_q <= {bit_s_q[0], ltx_sh_q[ssp_pkg::WORD_W-1]};
        end
    end
    assign tx_active = act_s_q[1];
    assign tx_bit    = bit_s_q[1];
    assign tx1_bit   = bit_s_q[1];

    // rx word crossing by toggle, then buffered
    logic [2:0]                 rtog_q;
    logic                       rx_push;
    assign rx_push = rtog_q[2] != rtog_q[1];
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rtog_q <= 3'h0;
        end else begin
            rtog_q <= {rtog_q[1:0], lrx_tog_q};
        end
    end

    ssp_buf2 u_rxbuf (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_valid (rx_push),
        .o_ready (),
        .i_data  (lrx_word_q),
        .o_valid (o_rx_valid),
        .i_ready (i_rx_ready),
        .o_data  (o_rx_data)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset inputs
    chk_reset_gpio_in: assert property (@(posedge i_clk)
        $fell(i_rst) |-> o_pin_oe == 6'h00)
        else $error("pins not inputs after reset");
    chk_wait_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        pwr_q == ssp_pkg::SSP_WAIT ##1 pwr_q == ssp_pkg::SSP_WAIT
        |-> $stable(o_pin) && $stable(o_pin_oe))
        else $error("pins changed in wait");
    chk_stop_keep: assert property (@(posedge i_clk) disable iff (i_rst)
        stopped && $past(stopped) |-> $stable(o_pin))
        else $error("pin level moved in stop");
    chk_stop_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
        stopped && $past(stopped) |-> $stable(o_gpio_in))
        else $error("input seen in stop");
    chk_gpio_dir: assert property (@(posedge i_clk) disable iff (i_rst)
        pwr_q == ssp_pkg::SSP_RUN && i_pin_sel == 6'h00
        |=> o_pin_oe == $past(i_pin_dir))
        else $error("gpio direction wrong");
    chk_rx_input: assert property (@(posedge i_clk) disable iff (i_rst)
        pwr_q == ssp_pkg::SSP_RUN && i_pin_sel[4]
        |=> !o_pin_oe[4])
        else $error("rx pin driven");
    chk_tx_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        pwr_q == ssp_pkg::SSP_RUN && i_pin_sel[5]
        |=> o_pin_oe[5] == $past(tx_active))
        else $error("tx drive wrong");
    chk_fs_out: assert property (@(posedge i_clk) disable iff (i_rst)
        pwr_q == ssp_pkg::SSP_RUN && i_pin_sel[2] && i_fs_out
        |=> o_pin_oe[2] && o_pin[2])
        else $error("frame sync not driven");
    chk_flag0: assert property (@(posedge i_clk) disable iff (i_rst)
        pwr_q == ssp_pkg::SSP_RUN && i_pin_sel[0] && !i_async_mode
        && i_flag_mode |=> o_pin[0] == $past(i_flag_out[0]))
        else $error("flag zero wrong");
    cov_stop: cover property (@(posedge i_clk) stopped);
    cov_wait: cover property (@(posedge i_clk)
        pwr_q == ssp_pkg::SSP_WAIT);
    cov_rx: cover property (@(posedge i_clk) o_rx_valid && i_rx_ready);
endmodule : ssp_port

// >>> bench/ssp_peer.sv
// ssp_peer: far-side codec model, one receive frame per start pulse
// assumes: start seen on an i_clk edge, word held while busy
`timescale 1ns/10ps
module ssp_peer (
    // system side
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic [15:0] i_word,
    output logic             o_busy,
    // link side
    output logic             o_lclk,
    output logic             o_fs,
    output logic             o_rxd,
    input  wire logic        i_txd,
    output logic [15:0]      o_txw
);
    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    // bit period 300 ns, three system phases or more per half
    task automatic bit_cyc;
        // txd taken late in the bit, once the pad has settled
        #145 o_txw = {o_txw[14:0], i_txd};
        #5 o_lclk = 1'b1;
        #150 o_lclk = 1'b0;
    endtask : bit_cyc

    // one link edge inside reset; clock then stands still
    initial begin
        o_lclk = 1'b0;
        o_fs = 1'b0;
        o_rxd = 1'b0;
        o_busy = 1'b0;
        o_txw = 16'h0000;
        #40 bit_cyc();
    end

    always begin
        @(posedge i_clk);
        if (i_start) begin
            o_busy = 1'b1;
            o_fs = 1'b1;
            bit_cyc();
            o_fs = 1'b0;
            for (int i = 15; i >= 0; i--) begin
                o_rxd = i_word[i];
                bit_cyc();
            end
            // released line must not look like a held bit
            o_rxd = ~o_rxd;
            o_busy = 1'b0;
        end
    end
endmodule : ssp_peer

// >>> bench/sync_serial_port1_pins_test.sv
// sync_serial_port1_pins_test: self-checking bench for ssp_port
// assumes: ssp_peer on the link; pads resolved here from out/oe
`timescale 1ns/10ps
module sync_serial_port1_pins_test;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [5:0]  sel, dir, gout, rnd, o_gpio_in, o_pin, o_pin_oe;
    logic        async, bclk_o, fs_o, rxfs_o, flag_m, stop, wait_s;
    logic [1:0]  flag_o;
    logic        tx_v, o_tx_ready, o_rx_valid, rx_rdy, start, r;
    logic [15:0] tx_d, o_rx_data, word;
    wire  [5:0]  ext, pin;
    wire         lclk, fs, rxd, busy;
    integer      seed = 32'hB9F4D951;
    int          err_count = 0;
    int          checks_done = 0;
    logic [15:0] q[$], tq[$];
    wire  [15:0] txw;
    bit          tx_on = 1'b0;
    assign ext = {rnd[5], rxd, rnd[3], fs, rnd[1:0]};
    assign pin = (o_pin_oe & o_pin) | (~o_pin_oe & ext);
    always #50 i_clk = ~i_clk;

    ssp_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_lclk(lclk),
        .i_pin_sel(sel), .i_pin_dir(dir), .i_gpio_out(gout),
        .o_gpio_in(o_gpio_in), .i_async_mode(async), .i_bclk_out(bclk_o),
        .i_fs_out(fs_o), .i_rx_fs_out(rxfs_o), .i_flag_mode(flag_m),
        .i_flag_out(flag_o), .i_stop(stop), .i_wait(wait_s),
        .i_tx_valid(tx_v), .o_tx_ready(o_tx_ready), .i_tx_data(tx_d),
        .o_rx_valid(o_rx_valid), .i_rx_ready(rx_rdy),
        .o_rx_data(o_rx_data), .i_pin(pin), .o_pin(o_pin),
        .o_pin_oe(o_pin_oe));
    ssp_peer peer_u (.i_clk(i_clk), .i_start(start), .i_word(word),
        .o_busy(busy), .o_lclk(lclk), .o_fs(fs), .o_rxd(rxd),
        .i_txd(pin[5]), .o_txw(txw));

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic note(input string m);
        err_count++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : note
    task automatic cmp6(input logic [5:0] g, input logic [5:0] e);
        checks_done++;
        if (g !== e) note($sformatf("pins %h want %h", g, e));
    endtask : cmp6
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) note($sformatf("word %h want %h", g, e));
    endtask : cmp16
    task automatic close_out;
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc

    // ------------------------------------------------------------
    // scenario helpers
    // ------------------------------------------------------------
    task automatic frame(input logic [15:0] w);
        q.push_back(w);
        @(posedge i_clk);
        start <= 1'b1;
        word <= w;
        @(posedge i_clk);
        start <= 1'b0;
        for (int t = 0; t <= 70; t++) begin
            @(negedge i_clk);
            if (busy === 1'b0) break;
            if (t == 70) begin
                note("frame hung");
                close_out();
            end
        end
    endtask : frame
    task automatic drain;
        for (int t = 0; t <= 60; t++) begin
            @(negedge i_clk);
            if (q.size() == 0) break;
            if (t == 60) begin
                note("rx word missing");
                close_out();
            end
        end
    endtask : drain
    // stop when s, else wait: driven levels must freeze, and inputs too when s
    task automatic pwr(input bit s);
        logic [5:0] e_in;
        @(posedge i_clk);
        dir <= 6'h0F;
        gout <= 6'h05;
        cyc(6);
        @(negedge i_clk);
        e_in = ext & 6'h30;
        @(posedge i_clk);
        if (s) stop <= 1'b1;
        else wait_s <= 1'b1;
        @(posedge i_clk);
        dir <= 6'h30;
        gout <= 6'h3A;
        rnd <= ~rnd;
        cyc(6);
        @(negedge i_clk);
        cmp6(o_pin_oe, 6'h0F);
        cmp6(o_pin & 6'h0F, 6'h05);
        if (s) cmp6(o_gpio_in & 6'h30, e_in);
        @(posedge i_clk);
        stop <= 1'b0;
        wait_s <= 1'b0;
        cyc(6);
    endtask : pwr

    // ------------------------------------------------------------
    // receive monitor
    // ------------------------------------------------------------
    always @(negedge i_clk) begin
        if (!i_rst && o_rx_valid === 1'b1 && rx_rdy === 1'b1) begin
            if (q.size() == 0) note("unexpected rx word");
            else cmp16(o_rx_data, q.pop_front());
        end
    end
    // transmit word as the peer saw it on the pad, at frame end
    always @(negedge busy) begin
        if (tx_on && tq.size() != 0) cmp16(txw, tq.pop_front());
        else if (tx_on) note("unexpected tx word");
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {sel, dir, gout, rnd, flag_o} = '0;
        {async, bclk_o, fs_o, rxfs_o, flag_m, stop, wait_s} = '0;
        {tx_v, rx_rdy, start, tx_d, word} = '0;
        @(negedge i_clk);
        cmp6(o_pin_oe, 6'h00);
        cmp6(o_gpio_in | o_pin, 6'h00);
        cmp6({4'h0, o_rx_valid, o_tx_ready}, 6'h01);
        cyc(2);
        i_rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            dir <= 6'($random(seed));
            gout <= 6'($random(seed));
            rnd <= 6'($random(seed));
            cyc(6);
            @(negedge i_clk);
            cmp6(o_pin_oe, dir);
            cmp6(o_pin & dir, gout & dir);
            cmp6(o_gpio_in & ~dir, ext & ~dir);
        end
        pwr(1'b0);
        pwr(1'b1);
        for (int f = 0; f < 4; f++) begin
            @(posedge i_clk);
            sel <= 6'h0F;
            flag_m <= 1'b1;
            flag_o <= f[1:0];
            fs_o <= 1'b1;
            bclk_o <= 1'b1;
            cyc(3);
            @(negedge i_clk);
            cmp6(o_pin_oe & 6'h0F, 6'h0F);
            cmp6(o_pin & 6'h0B, {4'h0, f[1:0]});
        end
        @(posedge i_clk);
        sel <= 6'h02;
        async <= 1'b1;
        flag_m <= 1'b0;
        cyc(3);
        @(negedge i_clk);
        cmp6(o_pin_oe & 6'h02, 6'h00);
        @(posedge i_clk);
        {async, fs_o, bclk_o} <= 3'h0;
        sel <= 6'h3C;
        dir <= 6'h00;
        // fill the transmit side until it refuses
        @(posedge i_clk);
        tx_v <= 1'b1;
        tx_d <= 16'($random(seed));
        for (int k = 0; k < 6; k++) begin
            @(negedge i_clk);
            r = o_tx_ready;
            @(posedge i_clk);
            if (r === 1'b1) begin
                tq.push_back(tx_d);
                tx_d <= 16'($random(seed));
            end else begin
                break;
            end
        end
        tx_v <= 1'b0;
        cmp6({5'h0, r}, 6'h00);
        // receiver stalls across two frames, then drains
        // first frame only primes the link side, no tx word yet
        frame(16'($random(seed)));
        tx_on = 1'b1;
        frame(16'h8001);
        cyc(10);
        rx_rdy <= 1'b1;
        drain();
        frame(16'hFFFF);
        frame(16'h0000);
        drain();
        @(negedge i_clk);
        cmp6({5'h0, o_tx_ready}, 6'h01);
        cmp6(6'(tq.size()), 6'h00);
        close_out();
    end
endmodule : sync_serial_port1_pins_test
